// [design/motor_input_consts.svh]
// Constants for the motor input command logic: function codes, setting codes,
// field sizes and timing figures. Included by the package and the design files.
`ifndef MOTOR_INPUT_CONSTS_SVH
`define MOTOR_INPUT_CONSTS_SVH

// Terminal count and function code width
`define TERM_COUNT 5
`define FUNC_W 8

// Terminal function codes
`define FUNC_START_PULSE 8'h14
`define FUNC_STOP_HOLD 8'h15
`define FUNC_DIR_SELECT 8'h16
`define FUNC_LOOP_SUSPEND 8'h17
`define FUNC_INT_CLEAR 8'h18
`define FUNC_FREQ_RAISE 8'h1b
`define FUNC_FREQ_LOWER 8'h1c
`define FUNC_MEM_CLEAR 8'h1d

// Setting codes
`define RUN_SRC_TERMINAL 2'h1
`define LOOP_ENABLED 2'h1
`define FREQ_SRC_OPERATOR 2'h2

// Frequency word width and ramp counter width
`define FREQ_W_DEFAULT 16
`define RAMP_W 16

// Timing: clock period, one millisecond, debounce and minimum ON time
`define CLK_PERIOD_NS 25
`define MS_TIME_NS 1000000
`define MS_TICK_CYCLES_DEFAULT (`MS_TIME_NS / `CLK_PERIOD_NS)
`define DEBOUNCE_MS_DEFAULT 10
`define MIN_ON_MS 50

`endif

// [design/motor_input_pkg.sv]
// Types shared by the motor input command logic.
// Assumes motor_input_consts.svh is on the include path.
`include "motor_input_consts.svh"

package motor_input_pkg;
    // One function code per programmable terminal
    typedef logic [`TERM_COUNT-1:0][`FUNC_W-1:0] func_arr_t;
    // Two-digit selection settings
    typedef logic [1:0] select_t;
    // Raise/lower adjustment state, one-hot
    typedef enum logic [2:0] {
        ADJ_IDLE = 3'b001,
        ADJ_RAISE = 3'b010,
        ADJ_LOWER = 3'b100
    } adj_e;
endpackage

// [design/input_debounce.sv]
// Debounce filter for the programmable input terminals.
// Assumes raw inputs synchronous to i_clk and a one-cycle millisecond tick.
`timescale 1ns/1ps
`include "motor_input_consts.svh"

module input_debounce #(
    parameter int WIDTH = `TERM_COUNT,
    parameter int STABLE_MS = `DEBOUNCE_MS_DEFAULT
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_tick,
    input wire logic [WIDTH-1:0] i_raw,
    output logic [WIDTH-1:0] o_clean
);
    localparam int CW = $clog2(STABLE_MS + 1);
    localparam logic [CW-1:0] LAST = CW'(STABLE_MS - 1);

    // Filtered levels and per-terminal stability counters
    typedef struct packed {
        logic [WIDTH-1:0] clean;
        logic [WIDTH-1:0][CW-1:0] cnt;
    } deb_s;

    deb_s st;
    deb_s next_st;

    ////////////////////////////////////////////////////////////////////////
    // A level is taken only once it differs from the filtered value at
    // STABLE_MS successive ticks; any bounce restarts the count
    always_comb begin
        next_st = st;
        for (int i = 0; i < WIDTH; i++) begin
            if (i_raw[i] == st.clean[i]) begin
                next_st.cnt[i] = '0;
            end else if (i_tick) begin
                if (st.cnt[i] >= LAST) begin
                    next_st.clean[i] = i_raw[i];
                    next_st.cnt[i] = '0;
                end else begin
                    next_st.cnt[i] = st.cnt[i] + CW'(1);
                end
            end
        end
    end

    // State register
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_clean = st.clean;
endmodule // input_debounce

// [design/motor_input_command_logic.sv]
// Command logic behind the five programmable input terminals: three-wire
// start/stop/direction, control-loop suspend and integrator clear, and the
// remote raise/lower frequency function with its memory.
// Assumes terminal inputs and settings synchronous to a 40 MHz i_clk.
//
// Functional notes
// RQ1: Codes 20/21/22 on terminals enable three-wire control.
// RQ2: Operator sets run source 01 for three-wire.
// RQ3: Start pulse acts on OFF-to-ON edge only.
// RQ4: Stop hold OFF stops motor, ON no change.
// RQ5: Direction level: ON reverse, OFF forward.
// RQ6: Three-wire disables forward and reverse run terminals.
// RQ7: Code 23 ON suspends loop; else enable decides.
// RQ8: Code 24 ON forces loop integrator to zero.
// RQ9: Controller avoids suspend/clear changes while running.
// RQ10: Code 27 ON raises frequency; OFF holds it.
// RQ11: Code 28 ON lowers frequency; OFF holds it.
// RQ12: Ramps use first or second-set ramp times.
// RQ13: Memory enable decides retention across power loss.
// RQ14: Code 29 ON clears memory to set frequency.
// RQ15: Raise/lower only with source 02, not jog.
// RQ16: Adjusted frequency clamped to zero and maximum.
// RQ17: Controller holds raise/lower ON at least 50 ms.
// RQ18: Adjustment starts from stored output frequency setting.
// RQ19: Per-terminal function codes; inputs debounced synchronously.
`timescale 1ns/1ps
`include "motor_input_consts.svh"

module motor_input_command_logic #(
    parameter int MS_TICK_CYCLES = `MS_TICK_CYCLES_DEFAULT,
    parameter int DEBOUNCE_MS = `DEBOUNCE_MS_DEFAULT,
    parameter int FREQ_W = `FREQ_W_DEFAULT
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic [`TERM_COUNT-1:0] i_term,
    input wire motor_input_pkg::func_arr_t i_term_func,
    input wire motor_input_pkg::select_t i_run_source_select,
    input wire motor_input_pkg::select_t i_freq_source_select,
    input wire motor_input_pkg::select_t i_loop_enable_setting,
    input wire logic i_adjust_memory_enable,
    input wire logic i_jog_input,
    input wire logic i_power_restore,
    input wire logic i_second_set_active,
    input wire logic [`RAMP_W-1:0] i_first_accel_time,
    input wire logic [`RAMP_W-1:0] i_first_decel_time,
    input wire logic [`RAMP_W-1:0] i_second_accel_time,
    input wire logic [`RAMP_W-1:0] i_second_decel_time,
    input wire logic [FREQ_W-1:0] i_max_freq_setting,
    input wire logic [FREQ_W-1:0] i_output_freq_setting,
    output logic o_three_wire_active,
    output logic o_forward_run_enable,
    output logic o_reverse_run_enable,
    output logic o_run,
    output logic o_reverse,
    output logic o_loop_run,
    output logic o_integrator_clear,
    output logic [FREQ_W-1:0] o_freq_setpoint
);
    import motor_input_pkg::*;

    localparam int MS_W = $clog2(MS_TICK_CYCLES);
    localparam logic [MS_W-1:0] MS_LAST = MS_W'(MS_TICK_CYCLES - 1);

    ////////////////////////////////////////////////////////////////////////
    // Decoding helpers

    // True when any terminal carries the given function code
    function automatic logic func_assigned(input func_arr_t funcs, input logic [`FUNC_W-1:0] code);
        func_assigned = 1'b0;
        for (int i = 0; i < `TERM_COUNT; i++) begin
            if (funcs[i] == code) begin
                func_assigned = 1'b1;
            end
        end
    endfunction

    // True when a terminal with the given function code is ON
    function automatic logic func_on(input func_arr_t funcs, input logic [`TERM_COUNT-1:0] lvl,
                                     input logic [`FUNC_W-1:0] code);
        func_on = 1'b0;
        for (int i = 0; i < `TERM_COUNT; i++) begin
            if (funcs[i] == code && lvl[i]) begin
                func_on = 1'b1;
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic three_wire;            // Three-wire mode in force
        logic fwd_enable;            // Forward-run terminal allowed
        logic rev_enable;            // Reverse-run assignment allowed
        logic run;                   // Three-wire run latch
        logic reverse;               // Direction, 1 = reverse
        logic start_prev;            // Start level one cycle back
        logic loop_run;              // Control loop may execute
        logic int_clear;             // Integrator held at zero
        adj_e adj;                   // Raise/lower state
        logic adjusted;              // Raise/lower active at a tick since last clear or restore without memory
        logic [FREQ_W-1:0] freq;     // Adjusted frequency
        logic [FREQ_W-1:0] base;     // Frequency before adjustment
        logic [FREQ_W-1:0] setpoint; // Frequency handed to the drive
        logic [`RAMP_W-1:0] ramp_cnt; // Milliseconds since last step
        logic [MS_W-1:0] ms_cnt;     // Millisecond divider
        logic ms_tick;               // One-cycle millisecond enable
    } state_s;

    localparam state_s ST_RESET = '{adj: ADJ_IDLE, fwd_enable: 1'b1, rev_enable: 1'b1, default: '0};

    state_s st;
    state_s next_st;
    logic rst_meta;                  // Reset release, first stage
    logic rst_sync;                  // Reset release used by the design
    logic [`TERM_COUNT-1:0] clean;   // Debounced terminal levels

    // Decoded terminal functions
    logic start_on;
    logic stop_on;
    logic dir_on;
    logic suspend_on;
    logic iclr_on;
    logic up_on;
    logic dn_on;
    logic mclr_on;
    logic three_wire_cfg;
    logic adj_avail;
    logic [`RAMP_W-1:0] accel_time;
    logic [`RAMP_W-1:0] decel_time;
    logic [FREQ_W-1:0] set_clamped;

    ////////////////////////////////////////////////////////////////////////
    // Reset release through two flip-flops
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    // Debounced sampling of all five terminals
    input_debounce #(
        .WIDTH(`TERM_COUNT),
        .STABLE_MS(DEBOUNCE_MS)
    ) u_debounce (
        .i_clk(i_clk),
        .i_rst_n(rst_sync),
        .i_tick(st.ms_tick),
        .i_raw(i_term),
        .o_clean(clean)
    ); // RQ19

    ////////////////////////////////////////////////////////////////////////
    // Function decode from per-terminal codes
    always_comb begin
        start_on = func_on(i_term_func, clean, `FUNC_START_PULSE); // RQ19
        stop_on = func_on(i_term_func, clean, `FUNC_STOP_HOLD);
        dir_on = func_on(i_term_func, clean, `FUNC_DIR_SELECT);
        suspend_on = func_on(i_term_func, clean, `FUNC_LOOP_SUSPEND);
        iclr_on = func_on(i_term_func, clean, `FUNC_INT_CLEAR);
        up_on = func_on(i_term_func, clean, `FUNC_FREQ_RAISE);
        dn_on = func_on(i_term_func, clean, `FUNC_FREQ_LOWER);
        mclr_on = func_on(i_term_func, clean, `FUNC_MEM_CLEAR);
        // All three functions assigned and terminals own the run command
        three_wire_cfg = func_assigned(i_term_func, `FUNC_START_PULSE)
                       && func_assigned(i_term_func, `FUNC_STOP_HOLD)
                       && func_assigned(i_term_func, `FUNC_DIR_SELECT)
                       && i_run_source_select == `RUN_SRC_TERMINAL; // RQ1 RQ2
        // Raise/lower only under operator frequency source, never with jog
        adj_avail = i_freq_source_select == `FREQ_SRC_OPERATOR && !i_jog_input; // RQ15
        // Ramp times follow the active set
        accel_time = i_second_set_active ? i_second_accel_time : i_first_accel_time; // RQ12
        decel_time = i_second_set_active ? i_second_decel_time : i_first_decel_time; // RQ12
        set_clamped = i_output_freq_setting > i_max_freq_setting ? i_max_freq_setting
                                                                 : i_output_freq_setting;
    end

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        next_st = st;

        // Millisecond enable from the clock divider
        next_st.ms_tick = 1'b0;
        if (st.ms_cnt >= MS_LAST) begin
            next_st.ms_cnt = '0;
            next_st.ms_tick = 1'b1;
        end else begin
            next_st.ms_cnt = st.ms_cnt + MS_W'(1);
        end

        // Three-wire mode blocks the level run terminals
        next_st.three_wire = three_wire_cfg;
        next_st.fwd_enable = !three_wire_cfg; // RQ6
        next_st.rev_enable = !three_wire_cfg; // RQ6

        // Start edge, stop level; stop wins over a simultaneous start
        next_st.start_prev = start_on;
        if (!three_wire_cfg) begin
            next_st.run = 1'b0;
        end else if (!stop_on) begin
            next_st.run = 1'b0; // RQ4
        end else if (start_on && !st.start_prev) begin
            next_st.run = 1'b1; // RQ3
        end
        next_st.reverse = three_wire_cfg && dir_on; // RQ5

        // Control loop suspend and integrator clear
        next_st.loop_run = i_loop_enable_setting == `LOOP_ENABLED && !suspend_on; // RQ7
        next_st.int_clear = iclr_on; // RQ8

        // Raise/lower state; both inputs ON together hold the value
        if (!adj_avail || mclr_on) begin
            next_st.adj = ADJ_IDLE; // RQ15
        end else if (up_on && !dn_on) begin
            next_st.adj = ADJ_RAISE; // RQ10
        end else if (dn_on && !up_on) begin
            next_st.adj = ADJ_LOWER; // RQ11
        end else begin
            next_st.adj = ADJ_IDLE;
        end
        if (next_st.adj != st.adj) begin
            next_st.ramp_cnt = '0;
        end

        // Frequency memory
        if (mclr_on) begin
            // Memory erased, back to the stored setting
            next_st.freq = set_clamped; // RQ14
            next_st.base = set_clamped;
            next_st.adjusted = 1'b0;
        end else if (i_power_restore && !i_adjust_memory_enable) begin
            // Without memory the frequency from before adjustment returns
            next_st.freq = st.base; // RQ13
            next_st.adjusted = 1'b0;
        end else if (st.adj == ADJ_IDLE && !st.adjusted) begin
            // Follow the stored setting until an adjustment starts
            next_st.freq = set_clamped; // RQ18
            next_st.base = set_clamped;
        end else if (st.adj != ADJ_IDLE && st.ms_tick) begin
            next_st.adjusted = 1'b1;
            if (st.ramp_cnt + `RAMP_W'(1) >= (st.adj == ADJ_RAISE ? accel_time : decel_time)) begin
                next_st.ramp_cnt = '0;
                unique case (st.adj)
                    ADJ_RAISE: begin
                        if (st.freq < i_max_freq_setting) begin
                            next_st.freq = st.freq + FREQ_W'(1); // RQ10
                        end
                    end
                    ADJ_LOWER: begin
                        if (st.freq != '0) begin
                            next_st.freq = st.freq - FREQ_W'(1); // RQ11
                        end
                    end
                    ADJ_IDLE: begin
                        next_st.freq = st.freq;
                    end
                endcase
            end else begin
                next_st.ramp_cnt = st.ramp_cnt + `RAMP_W'(1);
            end
        end
        // Upper clamp also follows a lowered maximum
        if (next_st.freq > i_max_freq_setting) begin
            next_st.freq = i_max_freq_setting; // RQ16
        end

        // Drive setpoint: adjusted value only while the function applies
        next_st.setpoint = adj_avail ? next_st.freq : set_clamped; // RQ15
    end

    // State register
    always_ff @(posedge i_clk or negedge rst_sync) begin
        if (!rst_sync) begin
            st <= ST_RESET;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, all straight from the state register
    assign o_three_wire_active = st.three_wire;
    assign o_forward_run_enable = st.fwd_enable;
    assign o_reverse_run_enable = st.rev_enable;
    assign o_run = st.run;
    assign o_reverse = st.reverse;
    assign o_loop_run = st.loop_run;
    assign o_integrator_clear = st.int_clear;
    assign o_freq_setpoint = st.setpoint;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    a_start_edge: assert property ( // RQ3
        @(posedge i_clk) disable iff (!rst_sync)
        three_wire_cfg && stop_on && start_on && !st.start_prev |=> st.run && o_run)
        else $error("start edge did not set run");

    a_start_level: assert property ( // RQ3
        @(posedge i_clk) disable iff (!rst_sync)
        !st.run && start_on && st.start_prev |=> !st.run)
        else $error("steady start level started the motor");

    a_stop_level: assert property ( // RQ4
        @(posedge i_clk) disable iff (!rst_sync)
        !stop_on |=> !o_run)
        else $error("run stayed on with stop input off");

    a_dir_follow: assert property ( // RQ5
        @(posedge i_clk) disable iff (!rst_sync)
        three_wire_cfg |=> o_reverse == $past(dir_on))
        else $error("direction output does not follow select");

    a_run_terms_off: assert property ( // RQ6
        @(posedge i_clk) disable iff (!rst_sync)
        o_three_wire_active |-> !o_forward_run_enable && !o_reverse_run_enable)
        else $error("run terminals enabled in three-wire mode");

    a_loop_suspend: assert property ( // RQ7
        @(posedge i_clk) disable iff (!rst_sync)
        suspend_on || i_loop_enable_setting != `LOOP_ENABLED |=> !o_loop_run)
        else $error("loop runs while suspended or disabled");

    a_int_clear: assert property ( // RQ8
        @(posedge i_clk) disable iff (!rst_sync)
        $rose(iclr_on) |=> o_integrator_clear)
        else $error("integrator clear not applied");

    a_freq_clamp: assert property ( // RQ16
        @(posedge i_clk) disable iff (!rst_sync)
        ##1 st.freq <= $past(i_max_freq_setting))
        else $error("adjusted frequency above maximum");

    a_mem_clear: assert property ( // RQ14
        @(posedge i_clk) disable iff (!rst_sync)
        mclr_on && adj_avail |=> st.freq == $past(set_clamped) && !st.adjusted ##1 o_freq_setpoint == $past(st.freq))
        else $error("memory clear did not restore set frequency");

    a_adj_source: assert property ( // RQ15
        @(posedge i_clk) disable iff (!rst_sync)
        !adj_avail |=> st.adj == ADJ_IDLE && o_freq_setpoint == $past(set_clamped))
        else $error("raise/lower active outside operator source");
endmodule // motor_input_command_logic

// [verif/contact_bank.sv]
// Behavioural contacts and switches wired to the five programmable terminals.
// Assumes the bench changes the wanted contact state just after i_clk rises.
`timescale 1ns/1ps

module contact_bank (
    input wire logic i_clk,
    input wire logic [4:0] i_want,
    output logic [4:0] o_term
);
    logic [4:0] settled; // Last commanded contact state
    logic [4:0] moving; // Contacts that just moved
    int bounce; // Chatter cycles left

    ////////////////////////////////////////////////////////////////////////////
    // Moving contacts chatter before they rest, so the filter sees real noise
    initial begin
        settled = 5'h00;
        moving = 5'h00;
        bounce = 0;
        o_term = 5'h00;
    end
    always @(posedge i_clk) begin
        if (i_want !== settled) begin
            // New position: start chattering the moved contacts
            moving <= i_want ^ settled;
            settled <= i_want;
            bounce <= 3;
        end else if (bounce > 0) begin
            bounce <= bounce - 1;
        end
        // An open contact reads OFF, like a broken wire
        o_term <= (bounce > 0) ? ((settled & ~moving) | (~o_term & moving)) : settled;
    end
endmodule // contact_bank

// [verif/motor_input_command_logic_tb_top.sv]
// Self-checking bench: a queue-free integer model of the command rules is
// compared with the design after each settled change. Assumes 40 MHz clock.
`timescale 1ns/1ps
`include "motor_input_consts.svh"
`define CHK(what, exp, got) begin checks++; if ((got) !== (exp)) begin errors++; \
    $display("Error %s expected %0d seen %0d", what, exp, got); end end

module motor_input_command_logic_tb_top;
    import motor_input_pkg::*;
    logic clk = 1'b0; // Bench clock
    logic rstn = 1'b0; // Active-low reset
    logic [8:0] fn = 9'h000; // Logical state of each function contact
    int tmap [5] = '{8, 8, 8, 8, 8}; // Function index per terminal
    int maps [3][5] = '{'{0, 1, 2, 3, 4}, '{4, 3, 2, 1, 0}, '{5, 6, 7, 8, 8}};
    logic [7:0] codes [9] = '{`FUNC_START_PULSE, `FUNC_STOP_HOLD, `FUNC_DIR_SELECT, `FUNC_LOOP_SUSPEND,
        `FUNC_INT_CLEAR, `FUNC_FREQ_RAISE, `FUNC_FREQ_LOWER, `FUNC_MEM_CLEAR, 8'h00};
    logic [4:0] want; // Contact positions asked of the partner
    logic [4:0] term; // Terminal levels from the partner
    func_arr_t func = '0;
    select_t rsrc = 2'h0, fsrc = 2'h0, lenab = 2'h0;
    logic memen = 1'b0, jog = 1'b0, pwr = 1'b0, second = 1'b0;
    logic [15:0] setv = 16'h0014, maxf = 16'h00c8; // Set and maximum frequency
    logic [15:0] first_accel_time = 16'h0001, first_decel_time = 16'h0001, acc2 = 16'h00c8, dec2 = 16'h00c8; // Ramp times
    logic [31:0] seed = 32'd84726; // Random source
    int errors = 0, checks = 0;
    logic o_tw, o_fwd, o_rev_en, o_run, o_rev, o_loop, o_iclr;
    logic [15:0] o_sp;

    ////////////////////////////////////////////////////////////////////////////
    // Clock, contact routing, partner and design
    initial forever #12.5 clk = ~clk;
    always_comb for (int t = 0; t < 5; t++) want[t] = fn[tmap[t]];
    contact_bank contact_bank_inst (.i_clk(clk), .i_want(want), .o_term(term));
    motor_input_command_logic #(.MS_TICK_CYCLES(4), .DEBOUNCE_MS(1)) motor_input_command_logic_inst (
        .i_clk(clk), .i_rstn(rstn), .i_term(term), .i_term_func(func), .i_run_source_select(rsrc),
        .i_freq_source_select(fsrc), .i_loop_enable_setting(lenab), .i_adjust_memory_enable(memen),
        .i_jog_input(jog), .i_power_restore(pwr), .i_second_set_active(second),
        .i_first_accel_time(first_accel_time), .i_first_decel_time(first_decel_time), .i_second_accel_time(acc2),
        .i_second_decel_time(dec2), .i_max_freq_setting(maxf), .i_output_freq_setting(setv),
        .o_three_wire_active(o_tw), .o_forward_run_enable(o_fwd), .o_reverse_run_enable(o_rev_en),
        .o_run(o_run), .o_reverse(o_rev), .o_loop_run(o_loop), .o_integrator_clear(o_iclr),
        .o_freq_setpoint(o_sp));

    ////////////////////////////////////////////////////////////////////////////
    // Helpers: random source, waits, contact moves, closing
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic drive(input int f, input logic v);
        @(posedge clk);
        fn[f] <= v;
        settle(30);
    endtask
    task automatic set_map(input int m);
        @(posedge clk);
        for (int t = 0; t < 5; t++) begin
            func[t] <= codes[maps[m][t]];
            tmap[t] <= maps[m][t];
        end
        settle(30);
    endtask
    task automatic chk_3w(input logic tw, input logic run);
        `CHK("three_wire", tw, o_tw)
        `CHK("fwd_enable", ~tw, o_fwd)
        `CHK("rev_enable", ~tw, o_rev_en)
        `CHK("run", run, o_run)
    endtask
    task automatic stop_test;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Watchdog well beyond the expected run length
    initial begin
        #1000000;
        errors++;
        stop_test();
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        settle(3);
        chk_3w(1'b0, 1'b0);
        `CHK("loop_rst", 1'b0, o_loop)
        settle(2);
        // Release on the sixth rising edge, like every other input
        @(posedge clk);
        rstn <= 1'b1;
        // Three-wire under two different terminal mappings
        for (int m = 0; m < 2; m++) begin
            set_map(m);
            @(posedge clk);
            rsrc <= `RUN_SRC_TERMINAL;
            drive(1, 1'b1);
            chk_3w(1'b1, 1'b0);
            drive(0, 1'b1);
            chk_3w(1'b1, 1'b1);
            drive(0, 1'b0);
            chk_3w(1'b1, 1'b1);
            for (int k = 0; k < 4; k++) begin
                seed = lfsr(seed);
                drive(2, seed[0]);
                `CHK("reverse", seed[0], o_rev)
            end
            drive(1, 1'b0);
            chk_3w(1'b1, 1'b0);
            drive(0, 1'b1);
            chk_3w(1'b1, 1'b0);
            drive(1, 1'b1);
            chk_3w(1'b1, 1'b0);
            drive(0, 1'b0);
            drive(0, 1'b1);
            chk_3w(1'b1, 1'b1);
            @(posedge clk);
            rsrc <= 2'h2;
            settle(30);
            chk_3w(1'b0, 1'b0);
            drive(0, 1'b0);
        end
        // Loop suspend and integrator clear over every enable code
        for (int c = 0; c < 16; c++) begin
            @(posedge clk);
            lenab <= select_t'(c >> 2);
            fn[3] <= c[0];
            fn[4] <= c[1];
            settle(30);
            `CHK("loop_run", ((c >> 2) == 1) && !c[0], o_loop)
            `CHK("int_clear", c[1], o_iclr)
        end
        // Raise and lower; contacts held well past the minimum ON time
        set_map(2);
        seed = lfsr(seed);
        @(posedge clk);
        fsrc <= `FREQ_SRC_OPERATOR;
        setv <= 16'd10 + 16'(seed % 40);
        second <= 1'b1;
        settle(30);
        `CHK("start_point", setv, o_sp)
        drive(5, 1'b1);
        settle(240);
        drive(5, 1'b0);
        `CHK("slow_ramp", 1'b1, (o_sp >= setv) && (o_sp <= setv + 16'd1))
        @(posedge clk);
        second <= 1'b0;
        drive(5, 1'b1);
        settle(240);
        drive(5, 1'b0);
        `CHK("fast_ramp", 1'b1, (o_sp >= setv + 16'd50) && (o_sp <= setv + 16'd78))
        drive(7, 1'b1);
        `CHK("mem_clear", setv, o_sp)
        drive(7, 1'b0);
        for (int p = 0; p < 2; p++) begin
            drive(5, 1'b1);
            settle(1000);
            drive(5, 1'b0);
            `CHK("raise_clamp", maxf, o_sp)
            settle(80);
            `CHK("raise_hold", maxf, o_sp)
            @(posedge clk);
            memen <= p[0];
            pwr <= 1'b1;
            @(posedge clk);
            pwr <= 1'b0;
            settle(30);
            `CHK("power_back", p ? maxf : setv, o_sp)
        end
        drive(6, 1'b1);
        settle(1000);
        drive(6, 1'b0);
        `CHK("lower_clamp", 16'h0000, o_sp)
        settle(80);
        `CHK("lower_hold", 16'h0000, o_sp)
        @(posedge clk);
        fsrc <= 2'h1;
        drive(5, 1'b1);
        `CHK("src_block", setv, o_sp)
        @(posedge clk);
        fsrc <= `FREQ_SRC_OPERATOR;
        jog <= 1'b1;
        setv <= 16'd250;
        settle(60);
        `CHK("jog_block", maxf, o_sp)
        stop_test();
    end
endmodule // motor_input_command_logic_tb_top
